// *** hdl/pll_clock_output_control.sv ***
// PLL settings and clock-output multiplexer with its register port.
// Assumes an analogue PLL outside that takes the ratio outputs and returns
// its clock on pll_clock_in, asynchronous to clk.
`timescale 1ns/1ns
module pll_clock_output_control
    import clock_out_pkg::*;
(
    input  wire logic       clk,                // System clock, 20 MHz
    input  wire logic       rst,                // Asynchronous reset
    input  wire logic [7:0] reg_addr,           // Register address
    input  wire logic [7:0] reg_wdata,          // Register write data
    input  wire logic       reg_write,          // Write strobe
    input  wire logic       reg_read,           // Read strobe
    output logic      [7:0] reg_rdata,          // Read data, next cycle
    input  wire logic [3:0] timer_overflow,     // Timer 0..3 overflow pulses
    input  wire logic       pll_clock_in,       // Analogue PLL output
    output logic      [4:0] loop_feedback_ratio, // Feedback division to PLL
    output logic      [7:0] loop_output_ratio,  // Output division to PLL
    output logic            pll_power_down,     // PLL power down
    input  wire logic       clock_output_pin_i, // Pin level in
    output logic            clock_output_pin_o, // Pin level out
    output logic            clock_output_pin_oe // Pin driven when high
);
    logic [7:0] ctrl_q, ctrl_d;
    logic [7:0] outdiv_q, outdiv_d;
    logic [7:0] rdata_q, rdata_d;
    logic [4:0] fb_q, fb_d;
    logic       pin_q, pin_d;
    logic       oe_q, oe_d;
    logic       pll_meta_q, pll_sync_q;
    logic       gpio_meta_q, gpio_sync_q;
    logic [3:0] phase;
    logic       timer_level;
    clock_sel_type sel;

    assign sel = clock_sel_type'(ctrl_q[sel_msb:sel_lsb]);

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    base_clock_divider u_div (
        .clk     (clk),
        .rst     (rst),
        .phase_q (phase)
    );

    timer_toggle u_tog (
        .clk       (clk),
        .rst       (rst),
        .overflow  (timer_overflow),
        .timer_sel (ctrl_q[sel_lsb+1:sel_lsb]),
        .toggle_q  (timer_level)
    );

    ////////////////////////////////////////////////////////////////////////
    // Synchronisers for the asynchronous PLL clock and the pin input
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pll_meta_q  <= 1'b0;
            pll_sync_q  <= 1'b0;
            gpio_meta_q <= 1'b0;
            gpio_sync_q <= 1'b0;
        end else begin
            pll_meta_q  <= pll_clock_in;
            pll_sync_q  <= pll_meta_q;
            gpio_meta_q <= clock_output_pin_i;
            gpio_sync_q <= gpio_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register writes and reads
    always_comb begin
        ctrl_d   = ctrl_q;
        outdiv_d = outdiv_q;
        rdata_d  = 8'h00;
        if (reg_write && reg_addr == ctrl_offset) begin
            ctrl_d = reg_wdata;
        end
        if (reg_write && reg_addr == outdiv_offset
            && reg_wdata >= outdiv_min) begin
            outdiv_d = reg_wdata;
        end
        if (reg_read) begin
            case (reg_addr)
                ctrl_offset:   rdata_d = ctrl_q;
                outdiv_offset: rdata_d = outdiv_q;
                status_offset: rdata_d = {4'h0, oe_q, gpio_sync_q,
                                          pll_sync_q, pin_q};
                default:       rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_q   <= ctrl_reset;
            outdiv_q <= outdiv_reset;
            rdata_q  <= 8'h00;
        end else begin
            ctrl_q   <= ctrl_d;
            outdiv_q <= outdiv_d;
            rdata_q  <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // PLL ratio decode and clock-output multiplexer
    always_comb begin
        fb_d  = fb_ratio(ctrl_q[fb_msb:fb_lsb]);
        pin_d = 1'b0;
        oe_d  = ctrl_q[enable_bit];
        case (sel)
            sel_gpio:   oe_d  = 1'b0;
            sel_pll:    pin_d = pll_sync_q & ~ctrl_q[pd_bit];
            sel_low:    pin_d = 1'b0;
            sel_high:   pin_d = 1'b1;
            sel_div1:   pin_d = phase[0];
            sel_div2:   pin_d = phase[1];
            sel_div4:   pin_d = phase[2];
            sel_div8:   pin_d = phase[3];
            sel_timer_zero,
            sel_timer1,
            sel_timer2,
            sel_timer_three: pin_d = timer_level;
            default:    oe_d  = 1'b0; // Reserved selections release the pin
        endcase
        if (!ctrl_q[enable_bit]) begin
            pin_d = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fb_q  <= fb_ratio_a;
            pin_q <= 1'b0;
            oe_q  <= 1'b0;
        end else begin
            fb_q  <= fb_d;
            pin_q <= pin_d;
            oe_q  <= oe_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all from flip-flops
    assign reg_rdata           = rdata_q;
    assign loop_feedback_ratio = fb_q;
    assign loop_output_ratio   = outdiv_q;
    assign pll_power_down      = ctrl_q[pd_bit];
    assign clock_output_pin_o  = pin_q;
    assign clock_output_pin_oe = oe_q;
endmodule

// *** hdl/clock_out_pkg.sv ***
// Constants, register map and encodings of the PLL and clock-output control.
// Assumes an 8-bit register port and one 20 MHz system clock.
//
// Behaviour
// - Select zero releases the clock pin for general-purpose use.
// - Select one routes the analogue PLL output to the clock pin.
// - Select two holds the pin low, select three holds it high.
// - Selects four to seven give the base clock divided by 1, 2, 4, 8.
// - Selects eight to eleven toggle on timer overflows; twelve up reserved.
// - Control bit 3 enables the clock output; cleared, no clock appears.
// - Feedback code 00 and 11 give 23, 01 gives 27, 10 gives 28.
// - Output divider divides by its value 8..254; values 0..7 are reserved.
// - PLL output equals input times feedback, halved, over output divider.
package clock_out_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register map
    localparam logic [7:0] ctrl_offset   = 8'h3d; // PLL and clock-out control
    localparam logic [7:0] outdiv_offset = 8'h3f; // PLL output divider
    localparam logic [7:0] status_offset = 8'h50; // Pin and PLL status

    localparam logic [7:0] ctrl_reset    = 8'h00;
    localparam logic [7:0] outdiv_reset  = 8'h08;
    localparam logic [7:0] outdiv_min    = 8'h08;

    // Control field positions
    localparam int sel_msb    = 7;
    localparam int sel_lsb    = 4;
    localparam int enable_bit = 3;
    localparam int pd_bit     = 2;
    localparam int fb_msb     = 1;
    localparam int fb_lsb     = 0;

    // Feedback division ratios
    localparam logic [4:0] fb_ratio_a = 5'h17; // 23
    localparam logic [4:0] fb_ratio_b = 5'h1b; // 27
    localparam logic [4:0] fb_ratio_c = 5'h1c; // 28

    ////////////////////////////////////////////////////////////////////////
    // Clock-output selections
    typedef enum logic [3:0] {
        sel_gpio   = 4'h0,
        sel_pll    = 4'h1,
        sel_low    = 4'h2,
        sel_high   = 4'h3,
        sel_div1   = 4'h4,
        sel_div2   = 4'h5,
        sel_div4   = 4'h6,
        sel_div8   = 4'h7,
        sel_timer_zero = 4'h8,
        sel_timer1 = 4'h9,
        sel_timer2 = 4'ha,
        sel_timer_three = 4'hb
    } clock_sel_type;

    // Feedback code to division ratio
    function automatic logic [4:0] fb_ratio(input logic [1:0] code);
        case (code)
            2'b01:   fb_ratio = fb_ratio_b;
            2'b10:   fb_ratio = fb_ratio_c;
            default: fb_ratio = fb_ratio_a;
        endcase
    endfunction

endpackage

// *** hdl/base_clock_divider.sv ***
// Free-running binary divider producing the base clock and its halves.
// Assumes the system clock; outputs are plain register bits.
`timescale 1ns/1ns
module base_clock_divider (
    input  wire logic       clk,      // System clock
    input  wire logic       rst,      // Asynchronous reset, active high
    output logic      [3:0] phase_q   // Bit n: base clock divided by 2**n
);
    logic [3:0] phase_d;

    ////////////////////////////////////////////////////////////////////////
    // Counter bits toggle at successive halvings
    always_comb begin
        phase_d = phase_q + 4'h1;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_q <= 4'h0;
        end else begin
            phase_q <= phase_d;
        end
    end
endmodule

// *** hdl/timer_toggle.sv ***
// Toggle flip-flop driven by the overflow of one selected timer.
// Assumes overflow pulses are one cycle wide on the system clock.
`timescale 1ns/1ns
module timer_toggle (
    input  wire logic       clk,        // System clock
    input  wire logic       rst,        // Asynchronous reset, active high
    input  wire logic [3:0] overflow,   // Timer overflow pulses, timers 0..3
    input  wire logic [1:0] timer_sel,  // Which timer drives the toggle
    output logic            toggle_q    // Toggled level
);
    logic toggle_d;

    ////////////////////////////////////////////////////////////////////////
    // Invert on each overflow of the chosen timer
    always_comb begin
        toggle_d = toggle_q ^ overflow[timer_sel];
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            toggle_q <= 1'b0;
        end else begin
            toggle_q <= toggle_d;
        end
    end
endmodule

// *** verification/clock_out_checker.sv ***
// Port-level assertions for the PLL and clock-output control.
// Assumes one clock; bound to the design's top module below.
`timescale 1ns/1ns
module clock_out_checker
    import clock_out_pkg::*;
(
    input wire logic       clk,                 // Clock
    input wire logic       rst,                 // Reset
    input wire logic [7:0] reg_addr,            // Address
    input wire logic [7:0] reg_wdata,           // Write data
    input wire logic       reg_write,           // Write strobe
    input wire logic [3:0] timer_overflow,      // Timer pulses
    input wire logic       pll_clock_in,        // PLL clock
    input wire logic [4:0] loop_feedback_ratio, // Feedback ratio
    input wire logic       clock_output_pin_o,  // Pin level
    input wire logic       clock_output_pin_oe  // Pin enable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////
    // Shadow of the control register
    logic [7:0] ctl_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            ctl_q <= ctrl_reset;
        else if (reg_write && reg_addr == ctrl_offset)
            ctl_q <= reg_wdata;
    end
    // Fields and short names
    wire [3:0] sel = ctl_q[7:4];
    wire       en  = ctl_q[3];
    wire       po  = clock_output_pin_o;
    wire       pe  = clock_output_pin_oe;
    wire       rsv = sel == 4'h0 || sel[3:2] == 2'b11;
    wire [1:0] fb  = ctl_q[1:0];
    ////////////////////////////////////////////////////////////////////
    // Properties
    sequence s_pll; sel == 4'h1 && en && !ctl_q[2]; endsequence
    sequence s_tick; sel[3:2] == 2'b10 && en && timer_overflow[sel[1:0]];
    endsequence
    sequence s_hold; sel[3:2] == 2'b10 && en && $stable(sel); endsequence
    property p_rel; rsv |=> !pe; endproperty
    property p_fix; sel[3:1] == 3'b001 && en |=> pe && po == $past(ctl_q[4]);
    endproperty
    property p_off; !rsv && !en |=> !pe && !po; endproperty
    property p_pll; s_pll ##1 s_pll |=> po == $past(pll_clock_in, 3);
    endproperty
    property p_pd; sel == 4'h1 && ctl_q[2] |=> !po; endproperty
    property p_div; (sel == 4'h4 && en) [*2] |=> po != $past(po); endproperty
    property p_tmr; s_tick ##1 s_hold |=> po != $past(po); endproperty
    property p_fb; $stable(ctl_q) |-> loop_feedback_ratio ==
        (fb == 2'b01 ? 5'h1b : fb == 2'b10 ? 5'h1c : 5'h17); endproperty
    a_rel: assert property (p_rel) else $error("pin not released");
    a_fix: assert property (p_fix) else $error("static level");
    a_off: assert property (p_off) else $error("disabled pin");
    a_pll: assert property (p_pll) else $error("pll route");
    a_pd: assert property (p_pd) else $error("pll not low");
    a_div: assert property (p_div) else $error("divider");
    a_tmr: assert property (p_tmr) else $error("timer toggle");
    a_fb: assert property (p_fb) else $error("feedback ratio");
endmodule
bind pll_clock_output_control clock_out_checker i_clock_out_checker (.*);

// *** verification/clock_pin_partner.sv ***
// Far side of the clock pin: an unpulled wire and the analogue PLL.
// Assumes the block's pin outputs; PLL runs even when powered down.
`timescale 1ns/1ns
module clock_pin_partner (
    input  wire logic clk,                 // System clock
    input  wire logic clock_output_pin_o,  // Driven level
    input  wire logic clock_output_pin_oe, // Drive enable
    output logic      clock_output_pin_i,  // Wire level
    output logic      pll_clock_in         // PLL clock
);
    logic last_q = 1'b0;
    // PLL clock on multiples of 36 ns, meeting a system clock edge every 900 ns
    initial pll_clock_in = 1'b0;
    always #36 pll_clock_in = ~pll_clock_in;
    // Released wire shows the inverse of its last driven level
    always @(posedge clk) if (clock_output_pin_oe) last_q <= clock_output_pin_o;
    assign clock_output_pin_i = clock_output_pin_oe ? clock_output_pin_o
                                                    : ~last_q;
endmodule

// *** verification/tb.sv ***
// Self-checking bench for the PLL and clock-output control.
// Assumes the partner model on the pin and the bound checker.
`timescale 1ns/1ns
module tb
    import clock_out_pkg::*;
;
    logic       clk = 1'b0, rst = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [3:0] timer_overflow = 4'h0;
    logic [7:0] loop_output_ratio, ctl_m = 8'h00, div_m = 8'h08, v;
    logic [4:0] loop_feedback_ratio;
    logic       pll_power_down, pll_clock_in, clock_output_pin_i, p;
    logic       clock_output_pin_o, clock_output_pin_oe;
    int         miscompares = 0, total_checks = 0, cyc = 0, n, t, e, s, k;
    pll_clock_output_control i_pll_clock_output_control (.*);
    clock_pin_partner i_clock_pin_partner (.*);
    ////////////////////////////////////////////////////////////////////
    // Clock and run limit
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            report_and_stop();
        end
    end
    // Verdict
    task automatic report_and_stop();
        if (miscompares == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Comparisons of bytes and of flags
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmp1(input logic got, input logic exp);
        cmp({7'h0, got}, {7'h0, exp});
    endtask
    // Register bus cycles, model updated beside them
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_write <= 1'b0;
        if (a == ctrl_offset) ctl_m = d;
        if (a == outdiv_offset && d >= 8'h08) div_m = d;
    endtask
    task automatic rd(input logic [7:0] a);
        v = a == ctrl_offset ? ctl_m : a == outdiv_offset ? div_m : 8'h00;
        @(posedge clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'b0;
        @(negedge clk);
        cmp(reg_rdata, v);
    endtask
    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        void'($urandom(32'h350d));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        wr(8'h10, 8'h55);
        rd(8'h10);
        // Output divider: reserved values alternate with legal ones
        for (k = 0; k < 16; k++) begin
            if (k[0]) v = 8'(k >> 1);
            else v = k == 2 ? 8'hfe : 8'(8 + $urandom % 247);
            if (k == 0) rd(outdiv_offset);
            wr(outdiv_offset, v);
            rd(outdiv_offset);
            cmp(loop_output_ratio, div_m);
        end
        // Every select with enable and power-down on and off
        for (k = 0; k < 64; k++) begin
            wr(ctrl_offset, {k[5:2], k[1], k[0], k[3:2]});
            rd(ctrl_offset);
            repeat (3) @(posedge clk);
            @(negedge clk);
            p = clock_output_pin_o;
            n = 0;
            t = 0;
            s = k[5:2];
            for (int j = 0; j < 40; j++) begin
                @(posedge clk);
                timer_overflow <= j < 32 ? 4'($urandom) : 4'h0;
                @(negedge clk);
                t += int'(timer_overflow[k[3:2]]);
                n += int'(clock_output_pin_o !== p);
                p = clock_output_pin_o;
            end
            e = !k[1] || s < 1 || s > 11 || (s < 4 && (s > 1 || k[0])) ? 0
              : s == 1 ? -1 : s < 8 ? 40 >> (s - 4) : t;
            cmp(8'(e < 0 ? int'(n > 0) : n), 8'(e < 0 ? 1 : e));
            cmp1(clock_output_pin_oe, s > 0 && s < 12 && k[1]);
            if (e == 0) cmp1(clock_output_pin_o, s == 3 && k[1]);
            cmp1(pll_power_down, k[0]);
            cmp({3'h0, loop_feedback_ratio}, k[3:2] == 1 ? 8'd27
                : k[3:2] == 2 ? 8'd28 : 8'd23);
        end
        report_and_stop();
    end
endmodule
